/* File: core/calbe_pkg.sv */
// Package: opcodes, carriers, flag positions and constants of the execution datapath
// Functional notes
// - Add and add-with-carry write the sum, update Z C N V H, one cycle.
// - Word add adds a constant to a register pair, Z C N V S, two cycles.
// - Word subtract takes a constant from a register pair, Z C N V S, two cycles.
// - Subtract and subtract-constant write the difference, Z C N V H, one cycle.
// - Subtracts with carry also take the carry away, Z C N V H, one cycle.
// - AND forms write the AND, only Z N V S change, one cycle.
// - OR forms and XOR write the result, only Z N V S change, one cycle.
// - Invert gives 0xff minus operand; arithmetic inverse 0x00 minus it, adds H.
// - Set-bits ORs the mask, clear-bits ANDs 0xff minus mask, Z N V, one cycle.
// - Add-one and subtract-one step by one, only Z N V S, carry kept.
// - Zero test ANDs a register with itself, keeps it, sets Z N V.
// - Zero-register XORs with itself (Z N V); fill-ones loads 0xff, no flags.
// - Products place the 16-bit result in R1:R0, update Z C, two cycles.
// - Fractional products write the product shifted left one, Z C, two cycles.
// - Relative jump PC+k+1 and indirect jump take 2 cycles, absolute 3.
// - Relative/indirect call 3 cycles, direct call 4, return pops PC in 4.
package calbe_pkg;
  localparam int unsigned CALBE_FLAG_C = 0;
  localparam int unsigned CALBE_FLAG_Z = 1;
  localparam int unsigned CALBE_FLAG_N = 2;
  localparam int unsigned CALBE_FLAG_V = 3;
  localparam int unsigned CALBE_FLAG_S = 4;
  localparam int unsigned CALBE_FLAG_H = 5;
  localparam int unsigned CALBE_FLAG_I = 7;
  localparam logic [7:0] CALBE_SREG_RST = 8'h00;
  localparam logic [7:0] CALBE_ONES = 8'hff;
  localparam logic [7:0] CALBE_ZERO = 8'h00;
  localparam logic [15:0] CALBE_PC_RST = 16'h0000;
  localparam logic [15:0] CALBE_STEP1 = 16'h0001;
  localparam logic [15:0] CALBE_STEP2 = 16'h0002;
  localparam logic [4:0] CALBE_R0_IDX = 5'h00;
  localparam logic [2:0] CALBE_CYC_ALU = 3'h1;
  localparam logic [2:0] CALBE_CYC_WORD = 3'h2;
  localparam logic [2:0] CALBE_CYC_PROD = 3'h2;
  localparam logic [2:0] CALBE_CYC_JUMP = 3'h2;
  localparam logic [2:0] CALBE_CYC_ABS = 3'h3;
  localparam logic [2:0] CALBE_CYC_CALL = 3'h3;
  localparam logic [2:0] CALBE_CYC_DCALL = 3'h4;
  localparam logic [2:0] CALBE_CYC_POP = 3'h4;
  localparam logic [11:0] CALBE_OFS_SREG = 12'h000;
  localparam logic [11:0] CALBE_OFS_PC = 12'h004;
  localparam logic [11:0] CALBE_OFS_STAT = 12'h008;

  typedef enum logic [5:0] {
    CALBE_OP_NOP, CALBE_OP_ADD, CALBE_OP_ADD_CARRY, CALBE_OP_WORD_ADD_IMM,
    CALBE_OP_SUB, CALBE_OP_SUB_CONST, CALBE_OP_SUB_CARRY, CALBE_OP_SUB_CONST_CARRY,
    CALBE_OP_WORD_SUB_IMM, CALBE_OP_AND, CALBE_OP_AND_CONST, CALBE_OP_OR,
    CALBE_OP_OR_CONST, CALBE_OP_XOR, CALBE_OP_INVERT, CALBE_OP_ARITH_INV,
    CALBE_OP_SET_BITS, CALBE_OP_CLR_BITS, CALBE_OP_ADD_ONE, CALBE_OP_SUB_ONE,
    CALBE_OP_ZERO_TEST, CALBE_OP_ZERO_REG, CALBE_OP_FILL_ONES, CALBE_OP_PROD_U,
    CALBE_OP_PROD_S, CALBE_OP_PROD_SU, CALBE_OP_FRAC_U, CALBE_OP_FRAC_S,
    CALBE_OP_FRAC_SU, CALBE_OP_REL_JUMP, CALBE_OP_IND_JUMP, CALBE_OP_ABS_JUMP,
    CALBE_OP_REL_CALL, CALBE_OP_IND_CALL, CALBE_OP_DIR_CALL, CALBE_OP_POP_PC,
    CALBE_OP_INT_EXIT
  } calbe_op_t;

  typedef enum logic {CALBE_IDLE, CALBE_RUN} calbe_state_t;

  typedef struct packed {
    calbe_op_t op;
    logic [4:0] rd_idx;     // Destination, low register of a pair
    logic [7:0] rd_val;
    logic [7:0] rd_hi_val;  // Upper register of the pair
    logic [7:0] src_val;
    logic [7:0] imm;
    logic [11:0] offs;      // Signed relative offset
    logic [15:0] target;    // Absolute target or pointer pair
    logic [15:0] pc;        // Address of this instruction
  } calbe_req_t;

  typedef struct packed {
    logic wr_byte;
    logic wr_word;
    logic [4:0] addr;
    logic [15:0] data;
  } calbe_wb_t;

  typedef struct packed {
    logic load;
    logic push;
    logic pop;
    logic [15:0] target;
    logic [15:0] ret_addr;
  } calbe_flow_t;

  function automatic logic [2:0] calbe_cycles(calbe_op_t op);
    case (op)
      CALBE_OP_WORD_ADD_IMM, CALBE_OP_WORD_SUB_IMM: calbe_cycles = CALBE_CYC_WORD;
      CALBE_OP_PROD_U, CALBE_OP_PROD_S, CALBE_OP_PROD_SU,
      CALBE_OP_FRAC_U, CALBE_OP_FRAC_S, CALBE_OP_FRAC_SU: calbe_cycles = CALBE_CYC_PROD;
      CALBE_OP_REL_JUMP, CALBE_OP_IND_JUMP: calbe_cycles = CALBE_CYC_JUMP;
      CALBE_OP_ABS_JUMP: calbe_cycles = CALBE_CYC_ABS;
      CALBE_OP_REL_CALL, CALBE_OP_IND_CALL: calbe_cycles = CALBE_CYC_CALL;
      CALBE_OP_DIR_CALL: calbe_cycles = CALBE_CYC_DCALL;
      CALBE_OP_POP_PC, CALBE_OP_INT_EXIT: calbe_cycles = CALBE_CYC_POP;
      default: calbe_cycles = CALBE_CYC_ALU;
    endcase
  endfunction
endpackage

/* File: core/calbe_mult.sv */
// Registered 8x8 multiplier with signed, mixed and fractional forms
`timescale 1ns/1ps
`default_nettype none
module calbe_mult (
  input wire logic clk_i,          // Core clock
  input wire logic nrst_i,         // Async reset, active low
  input wire logic en_i,           // Clock enable
  input wire logic start_i,        // Capture a new product
  input wire logic [7:0] a_i,      // First factor
  input wire logic [7:0] b_i,      // Second factor
  input wire logic a_signed_i,     // First factor is signed
  input wire logic b_signed_i,     // Second factor is signed
  input wire logic frac_i,         // Shift product left by one
  output logic [15:0] prod_o,      // Registered product
  output logic carry_o             // Registered bit 15 before the shift
);
  import calbe_pkg::*;
  logic [15:0] prod_q, prod_d;
  logic carry_q, carry_d;
  logic signed [8:0] sa, sb;
  logic signed [17:0] full;

  always_comb begin
    sa = $signed({a_signed_i & a_i[7], a_i});
    sb = $signed({b_signed_i & b_i[7], b_i});
    full = sa * sb;
    prod_d = prod_q;
    carry_d = carry_q;
    if (start_i) begin
      carry_d = full[15];
      prod_d = frac_i ? {full[14:0], 1'b0} : full[15:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prod_q <= 16'h0000;
      carry_q <= 1'b0;
    end else if (en_i) begin
      prod_q <= prod_d;
      carry_q <= carry_d;
    end
  end

  assign prod_o = prod_q;
  assign carry_o = carry_q;
endmodule
`default_nettype wire

/* File: core/calbe_exec.sv */
// Execution datapath: arithmetic, logic, products and unconditional flow
`timescale 1ns/1ps
`default_nettype none
module calbe_exec (
  input wire logic clk_i,                     // Core clock, 20 MHz
  input wire logic nrst_i,                    // Async reset, active low
  input wire logic en_i,                      // Clock enable, freezes all state
  input wire logic valid_i,                   // Decoder offers an operation
  output logic ready_o,                       // Block can take an operation
  input wire calbe_pkg::calbe_req_t req_i,    // Decoded operation and operands
  input wire logic [15:0] stack_top_i,        // Return address on top of stack
  output calbe_pkg::calbe_wb_t wb_o,          // Register file write, one-cycle
  output calbe_pkg::calbe_flow_t flow_o,      // PC load and stack strobes
  output logic [7:0] sreg_o,                  // Status flags
  input wire logic psel,                      // APB select
  input wire logic penable,                   // APB enable
  input wire logic pwrite,                    // APB direction
  input wire logic [11:0] paddr,              // APB byte address
  input wire logic [31:0] pwdata,             // APB write data
  output logic [31:0] prdata,                 // APB read data
  output logic pready,                        // APB ready
  output logic pslverr                        // APB error on unmapped address
);
  import calbe_pkg::*;

  // Sequencer
  calbe_state_t state_q, state_d;
  calbe_req_t req_q, req_d, cur;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sreg_q, sreg_d;
  calbe_wb_t wb_q, wb_d;
  calbe_flow_t flow_q, flow_d;

  logic [15:0] pc_last_q, pc_last_d;
  logic [15:0] retired_q, retired_d;
  logic [31:0] rdata_q, rdata_d;

  logic take, commit, is_prod, hit, sw_wr;

  // Multiplier
  logic [15:0] prod;
  logic prod_c;

  // Arithmetic scratch
  logic [7:0] a, b, res;
  logic [8:0] wide;
  logic [15:0] w16;
  logic [15:0] rel;
  logic cin, do_sub, do_add, upd_c, upd_h, upd_s, upd_znv, chain_z, logic_v;
  logic c_new, h_new, v_new;

  assign ready_o = (state_q == CALBE_IDLE);
  // Taken only when enabled
  assign take = valid_i && ready_o && en_i;
  // Held operands while busy
  assign cur = (state_q == CALBE_IDLE) ? req_i : req_q;
  assign commit = en_i && (((state_q == CALBE_IDLE) && take &&
                  (calbe_cycles(req_i.op) == CALBE_CYC_ALU)) ||
                  ((state_q == CALBE_RUN) && (cnt_q == 3'h0)));

  always_comb begin
    case (req_i.op)
      CALBE_OP_PROD_U, CALBE_OP_PROD_S, CALBE_OP_PROD_SU,
      CALBE_OP_FRAC_U, CALBE_OP_FRAC_S, CALBE_OP_FRAC_SU: is_prod = 1'b1;
      default: is_prod = 1'b0;
    endcase
  end

  // Product is captured at acceptance and read back at the closing edge
  calbe_mult u_mult (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .start_i(take && is_prod),
    .a_i(req_i.rd_val),
    .b_i(req_i.src_val),
    .a_signed_i(req_i.op inside {CALBE_OP_PROD_S, CALBE_OP_PROD_SU,
                                 CALBE_OP_FRAC_S, CALBE_OP_FRAC_SU}),
    .b_signed_i(req_i.op inside {CALBE_OP_PROD_S, CALBE_OP_FRAC_S}),
    .frac_i(req_i.op inside {CALBE_OP_FRAC_U, CALBE_OP_FRAC_S, CALBE_OP_FRAC_SU}),
    .prod_o(prod),
    .carry_o(prod_c)
  );

  // Byte arithmetic: operand selection
  always_comb begin
    a = cur.rd_val;
    b = cur.src_val;
    cin = 1'b0;
    do_add = 1'b0;
    do_sub = 1'b0;
    upd_c = 1'b0;
    upd_h = 1'b0;
    upd_znv = 1'b0;
    chain_z = 1'b0;
    logic_v = 1'b0;
    res = cur.rd_val;

    case (cur.op)
      CALBE_OP_ADD: begin
        do_add = 1'b1; upd_c = 1'b1; upd_h = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_ADD_CARRY: begin
        do_add = 1'b1; cin = sreg_q[CALBE_FLAG_C];
        upd_c = 1'b1; upd_h = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_SUB, CALBE_OP_SUB_CONST: begin
        if (cur.op == CALBE_OP_SUB_CONST) b = cur.imm;
        do_sub = 1'b1; upd_c = 1'b1; upd_h = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_SUB_CARRY, CALBE_OP_SUB_CONST_CARRY: begin
        if (cur.op == CALBE_OP_SUB_CONST_CARRY) b = cur.imm;
        cin = sreg_q[CALBE_FLAG_C];
        chain_z = 1'b1;
        do_sub = 1'b1; upd_c = 1'b1; upd_h = 1'b1; upd_znv = 1'b1;
      end
      // Logic forms clear V
      CALBE_OP_AND, CALBE_OP_AND_CONST, CALBE_OP_ZERO_TEST: begin
        if (cur.op == CALBE_OP_AND_CONST) b = cur.imm;
        if (cur.op == CALBE_OP_ZERO_TEST) b = cur.rd_val;
        res = a & b;
        logic_v = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_OR, CALBE_OP_OR_CONST, CALBE_OP_SET_BITS: begin
        if (cur.op != CALBE_OP_OR) b = cur.imm;
        res = a | b;
        logic_v = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_XOR, CALBE_OP_ZERO_REG: begin
        if (cur.op == CALBE_OP_ZERO_REG) b = cur.rd_val;
        res = a ^ b;
        logic_v = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_CLR_BITS: begin
        res = a & (CALBE_ONES - cur.imm);
        logic_v = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_INVERT: begin
        a = CALBE_ONES; b = cur.rd_val;
        do_sub = 1'b1; upd_c = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_ARITH_INV: begin
        a = CALBE_ZERO; b = cur.rd_val;
        do_sub = 1'b1; upd_c = 1'b1; upd_h = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_ADD_ONE: begin
        b = 8'h01; do_add = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_SUB_ONE: begin
        b = 8'h01; do_sub = 1'b1; upd_znv = 1'b1;
      end
      CALBE_OP_FILL_ONES: res = CALBE_ONES;
      default: res = cur.rd_val;
    endcase

    wide = 9'h000;
    if (do_add) begin
      wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      res = wide[7:0];
    end else if (do_sub) begin
      wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      res = wide[7:0];
    end

    c_new = wide[8];
    if (do_add) begin
      h_new = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
      v_new = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
    end else begin
      h_new = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
      v_new = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
    end
    if (cur.op == CALBE_OP_INVERT) c_new = 1'b1;

    if (logic_v) v_new = 1'b0;
  end

  // Word arithmetic and relative target
  always_comb begin
    upd_s = 1'b0;

    if (cur.op == CALBE_OP_WORD_SUB_IMM) begin
      w16 = {cur.rd_hi_val, cur.rd_val} - {8'h00, cur.imm};
      upd_s = 1'b1;
    end else begin
      w16 = {cur.rd_hi_val, cur.rd_val} + {8'h00, cur.imm};
      upd_s = (cur.op == CALBE_OP_WORD_ADD_IMM);
    end
    // Sign extension lets targets lie on either side of the instruction
    rel = cur.pc + {{4{cur.offs[11]}}, cur.offs} + CALBE_STEP1;
  end

  // Sequencing, flags, write-back and flow control
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    cnt_d = cnt_q;
    sreg_d = sreg_q;
    wb_d = '0;
    flow_d = '0;
    flow_d.target = flow_q.target;
    flow_d.ret_addr = flow_q.ret_addr;
    pc_last_d = pc_last_q;
    retired_d = retired_q;

    if (sw_wr) sreg_d = pwdata[7:0];

    if (take && !commit) begin
      req_d = req_i;
      cnt_d = calbe_cycles(req_i.op) - 3'h2;
      state_d = CALBE_RUN;
    end else if (state_q == CALBE_RUN && en_i && cnt_q != 3'h0) begin
      cnt_d = cnt_q - 3'h1;
    end

    if (commit) begin
      state_d = CALBE_IDLE;
      retired_d = retired_q + 16'h0001;

      // A completing operation wins over a software flag write
      sreg_d = sreg_q;
      wb_d.addr = cur.rd_idx;
      // S follows N and V
      if (upd_znv) begin
        sreg_d[CALBE_FLAG_Z] = (res == CALBE_ZERO) & (~chain_z | sreg_q[CALBE_FLAG_Z]);
        sreg_d[CALBE_FLAG_N] = res[7];
        sreg_d[CALBE_FLAG_V] = v_new;
        sreg_d[CALBE_FLAG_S] = res[7] ^ v_new;
      end
      if (upd_c) sreg_d[CALBE_FLAG_C] = c_new;
      if (upd_h) sreg_d[CALBE_FLAG_H] = h_new;

      // Per class results
      case (cur.op)
        CALBE_OP_WORD_ADD_IMM, CALBE_OP_WORD_SUB_IMM: begin
          wb_d.wr_word = 1'b1;
          wb_d.data = w16;
          sreg_d[CALBE_FLAG_Z] = (w16 == 16'h0000);
          sreg_d[CALBE_FLAG_N] = w16[15];
          if (upd_s && cur.op == CALBE_OP_WORD_SUB_IMM) begin
            sreg_d[CALBE_FLAG_V] = cur.rd_hi_val[7] & ~w16[15];
            sreg_d[CALBE_FLAG_C] = w16[15] & ~cur.rd_hi_val[7];
          end else begin
            sreg_d[CALBE_FLAG_V] = ~cur.rd_hi_val[7] & w16[15];
            sreg_d[CALBE_FLAG_C] = ~w16[15] & cur.rd_hi_val[7];
          end
          sreg_d[CALBE_FLAG_S] = sreg_d[CALBE_FLAG_N] ^ sreg_d[CALBE_FLAG_V];
        end
        CALBE_OP_PROD_U, CALBE_OP_PROD_S, CALBE_OP_PROD_SU,
        CALBE_OP_FRAC_U, CALBE_OP_FRAC_S, CALBE_OP_FRAC_SU: begin
          wb_d.wr_word = 1'b1;
          wb_d.addr = CALBE_R0_IDX;
          wb_d.data = prod;
          sreg_d[CALBE_FLAG_Z] = (prod == 16'h0000);
          sreg_d[CALBE_FLAG_C] = prod_c;
        end
        CALBE_OP_REL_JUMP, CALBE_OP_REL_CALL: begin
          flow_d.load = 1'b1;
          flow_d.target = rel;
          flow_d.push = (cur.op == CALBE_OP_REL_CALL);
          flow_d.ret_addr = cur.pc + CALBE_STEP1;
        end
        CALBE_OP_IND_JUMP, CALBE_OP_IND_CALL, CALBE_OP_ABS_JUMP, CALBE_OP_DIR_CALL: begin
          flow_d.load = 1'b1;
          flow_d.target = cur.target;
          flow_d.push = (cur.op == CALBE_OP_IND_CALL) ||
                        (cur.op == CALBE_OP_DIR_CALL);
          // A direct call is two words long, so it returns past both
          flow_d.ret_addr = (cur.op == CALBE_OP_DIR_CALL) ? cur.pc + CALBE_STEP2
                                                          : cur.pc + CALBE_STEP1;
        end
        CALBE_OP_POP_PC, CALBE_OP_INT_EXIT: begin
          flow_d.load = 1'b1;
          flow_d.pop = 1'b1;
          flow_d.target = stack_top_i;
          if (cur.op == CALBE_OP_INT_EXIT) sreg_d[CALBE_FLAG_I] = 1'b1;
        end
        CALBE_OP_NOP: wb_d.wr_byte = 1'b0;
        default: begin
          wb_d.wr_byte = 1'b1;
          wb_d.data = {8'h00, res};
        end
      endcase

      if (flow_d.load) pc_last_d = flow_d.target;
    end
  end

  // APB slave: zero wait states, read data staged during the setup phase
  always_comb begin
    hit = (paddr == CALBE_OFS_SREG) || (paddr == CALBE_OFS_PC) ||
          (paddr == CALBE_OFS_STAT);
    rdata_d = rdata_q;

    if (psel && !penable) begin
      case (paddr)
        CALBE_OFS_SREG: rdata_d = {24'h000000, sreg_q};
        CALBE_OFS_PC: rdata_d = {16'h0000, pc_last_q};
        CALBE_OFS_STAT: rdata_d = {retired_q, 15'h0000, ~ready_o};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Only the flag word takes writes
  assign sw_wr = en_i && psel && penable && pwrite && (paddr == CALBE_OFS_SREG);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = rdata_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= CALBE_IDLE;
      req_q <= '0;
      cnt_q <= 3'h0;
      sreg_q <= CALBE_SREG_RST;
      wb_q <= '0;
      flow_q <= '0;
      pc_last_q <= CALBE_PC_RST;
      retired_q <= 16'h0000;
      rdata_q <= 32'h00000000;
    end else if (en_i) begin
      state_q <= state_d;
      req_q <= req_d;
      cnt_q <= cnt_d;
      sreg_q <= sreg_d;
      wb_q <= wb_d;
      flow_q <= flow_d;
      pc_last_q <= pc_last_d;
      retired_q <= retired_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign wb_o = wb_q;
  assign flow_o = flow_q;
  assign sreg_o = sreg_q;
endmodule
`default_nettype wire

/* File: verif/calbe_exec_props.sv */
// Checker: timing and flag relations at the execution datapath ports
`timescale 1ns/1ps
`default_nettype none
module calbe_exec_props (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic en_i, // Enable
  input wire logic valid_i, // Offer
  input wire logic ready_o, // Idle
  input wire calbe_pkg::calbe_req_t req_i, // Request
  input wire logic [15:0] stack_top_i, // Stack top
  input wire calbe_pkg::calbe_wb_t wb_o, // Write back
  input wire calbe_pkg::calbe_flow_t flow_o, // Flow strobes
  input wire logic [7:0] sreg_o // Flags
);
  import calbe_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence take(calbe_op_t o);
    valid_i && ready_o && en_i && req_i.op == o;
  endsequence
  sequence held3;
    !flow_o.load [*3];
  endsequence
  byte_wb_a: assert property (take(CALBE_OP_ADD) |=> wb_o.wr_byte)
    else $error("add gave no byte write");
  word_wb_a: assert property (take(CALBE_OP_WORD_SUB_IMM) |=> !wb_o.wr_word ##1 wb_o.wr_word)
    else $error("word subtract latency wrong");
  prod_wb_a: assert property (take(CALBE_OP_PROD_S) |=> !ready_o ##1
    (wb_o.wr_word && wb_o.addr == CALBE_R0_IDX)) else $error("product write wrong");
  frac_data_a: assert property (take(CALBE_OP_FRAC_U) |-> ##2 wb_o.data ==
    ({8'h00, $past(req_i.rd_val, 2)} * {8'h00, $past(req_i.src_val, 2)}) << 1)
    else $error("fractional product wrong");
  jump_lat_a: assert property (take(CALBE_OP_REL_JUMP) |=> !flow_o.load ##1 flow_o.load)
    else $error("relative jump latency wrong");
  abs_lat_a: assert property (take(CALBE_OP_ABS_JUMP) |=> !flow_o.load [*2] ##1 flow_o.load)
    else $error("absolute jump latency wrong");
  dcall_lat_a: assert property (take(CALBE_OP_DIR_CALL) |=> held3 ##1 flow_o.push)
    else $error("direct call latency wrong");
  pop_pc_a: assert property (take(CALBE_OP_POP_PC) |-> ##4
    (flow_o.pop && flow_o.target == $past(stack_top_i))) else $error("return target wrong");
  iexit_en_a: assert property (take(CALBE_OP_INT_EXIT) |-> ##4 (flow_o.pop && sreg_o[7]))
    else $error("interrupt exit wrong");
  fill_flags_a: assert property (take(CALBE_OP_FILL_ONES) |=> $stable(sreg_o))
    else $error("fill changed flags");
  dec_carry_a: assert property (take(CALBE_OP_SUB_ONE) |=> $stable(sreg_o[0]))
    else $error("decrement changed carry");
endmodule
bind calbe_exec calbe_exec_props u_props (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i),
  .valid_i(valid_i), .ready_o(ready_o), .req_i(req_i), .stack_top_i(stack_top_i),
  .wb_o(wb_o), .flow_o(flow_o), .sreg_o(sreg_o));
`default_nettype wire

/* File: verif/calbe_stack_model.sv */
// Partner model: return stack behind the datapath
`timescale 1ns/1ps
`default_nettype none
module calbe_stack_model (
  input wire logic clk_i, // Core clock
  input wire logic nrst_i, // Async reset, active low
  input wire calbe_pkg::calbe_flow_t flow_i, // Push and pop strobes
  output logic [15:0] stack_top_o // Top entry
);
  import calbe_pkg::*;
  logic [15:0] mem_q [16];
  logic [3:0] sp_q;
  // Empty stack shows an inverted value so a stale read never looks valid
  assign stack_top_o = (sp_q == 4'h0) ? ~mem_q[0] : mem_q[sp_q - 4'h1];
  // Updated by non-blocking assignment so the datapath samples the old top
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp_q <= 4'h0;
    end else if (flow_i.push) begin
      mem_q[sp_q] <= flow_i.ret_addr;
      sp_q <= sp_q + 4'h1;
    end else if (flow_i.pop) begin
      sp_q <= sp_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: verif/test_cpu_arith_logic_branch_exec.sv */
// Testbench: random operations against a reference model
`timescale 1ns/1ps
`default_nettype none
module test_cpu_arith_logic_branch_exec;
  import calbe_pkg::*;
  logic clk_i = 0, nrst_i = 0, en_i = 1, valid_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic ready_o, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'd68;
  logic [15:0] stk_top, lt;
  logic [7:0] sreg, m_sreg = 8'h00;
  calbe_req_t req = '0;
  calbe_wb_t wb;
  calbe_flow_t flow;
  logic [15:0] stk[$];
  int num_errors = 0, n_tests = 0;
  always #25 clk_i = ~clk_i;
  calbe_exec u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .valid_i(valid_i),
    .ready_o(ready_o), .req_i(req), .stack_top_i(stk_top), .wb_o(wb), .flow_o(flow),
    .sreg_o(sreg), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  calbe_stack_model u_stack (.clk_i(clk_i), .nrst_i(nrst_i), .flow_i(flow), .stack_top_o(stk_top));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] model(calbe_req_t r, inout logic [7:0] s);
    int a, b, k, x;
    logic ad, sb, v, c;
    logic [15:0] y;
    a = r.rd_val;
    b = r.src_val;
    k = (r.op inside {CALBE_OP_ADD_CARRY, CALBE_OP_SUB_CARRY, CALBE_OP_SUB_CONST_CARRY}) ? s[0] : 0;
    if (r.op inside {CALBE_OP_WORD_ADD_IMM, CALBE_OP_WORD_SUB_IMM}) begin
      ad = (r.op == CALBE_OP_WORD_ADD_IMM);
      y = ad ? {r.rd_hi_val, r.rd_val} + r.imm : {r.rd_hi_val, r.rd_val} - r.imm;
      v = ad ? !r.rd_hi_val[7] && y[15] : r.rd_hi_val[7] && !y[15];
      s[0] = ad ? r.rd_hi_val[7] && !y[15] : y[15] && !r.rd_hi_val[7];
      s[4:1] = {y[15] ^ v, v, y[15], y == 16'h0000};
      return y;
    end
    if (r.op > CALBE_OP_FILL_ONES) begin
      if (r.op inside {CALBE_OP_PROD_S, CALBE_OP_PROD_SU, CALBE_OP_FRAC_S, CALBE_OP_FRAC_SU})
        a = $signed(r.rd_val);
      if (r.op inside {CALBE_OP_PROD_S, CALBE_OP_FRAC_S}) b = $signed(r.src_val);
      y = 16'(a * b);
      s[0] = y[15];
      if (r.op > CALBE_OP_PROD_SU) y = y << 1;
      s[1] = (y == 16'h0000);
      return y;
    end
    case (r.op)
      CALBE_OP_ADD_ONE, CALBE_OP_SUB_ONE: b = 1;
      CALBE_OP_ARITH_INV: begin a = 0; b = r.rd_val; end
      CALBE_OP_INVERT: begin a = 255; b = r.rd_val; end
      CALBE_OP_CLR_BITS: b = 255 - b;
      CALBE_OP_ZERO_TEST, CALBE_OP_ZERO_REG: b = a;
      default: ;
    endcase
    ad = r.op inside {CALBE_OP_ADD, CALBE_OP_ADD_CARRY, CALBE_OP_ADD_ONE};
    sb = r.op inside {[CALBE_OP_SUB:CALBE_OP_SUB_CONST_CARRY], CALBE_OP_SUB_ONE,
      CALBE_OP_INVERT, CALBE_OP_ARITH_INV};
    if (ad) x = a + b + k;
    else if (sb) x = a - b - k;
    else if (r.op inside {CALBE_OP_XOR, CALBE_OP_ZERO_REG}) x = a ^ b;
    else if (r.op inside {CALBE_OP_OR, CALBE_OP_OR_CONST, CALBE_OP_SET_BITS}) x = a | b;
    else x = (r.op == CALBE_OP_FILL_ONES) ? 255 : a & b;
    y = 16'(x & 255);
    v = (ad || sb) && (a[7] ^ y[7]) && (ad ? a[7] == b[7] : a[7] != b[7]);
    c = r.op inside {CALBE_OP_SUB_CARRY, CALBE_OP_SUB_CONST_CARRY};
    if (r.op != CALBE_OP_FILL_ONES) s[4:1] = {y[7] ^ v, v, y[7], y[7:0] == 8'h00 && (s[1] || !c)};
    if ((ad || sb) && !(r.op inside {CALBE_OP_ADD_ONE, CALBE_OP_SUB_ONE})) begin
      s[0] = (r.op == CALBE_OP_INVERT) || x < 0 || x > 255;
      if (r.op != CALBE_OP_INVERT) s[5] = ad ? (a % 16 + b % 16 + k > 15) : (a % 16 < b % 16 + k);
    end
    return y;
  endfunction
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(calbe_req_t r);
    logic [7:0] s;
    logic [15:0] e;
    logic wd;
    int i;
    s = m_sreg;
    e = model(r, s);
    wd = r.op inside {CALBE_OP_WORD_ADD_IMM, CALBE_OP_WORD_SUB_IMM} || r.op > CALBE_OP_FILL_ONES;
    @(posedge clk_i);
    valid_i <= 1'b1;
    req <= r;
    @(posedge clk_i);
    valid_i <= 1'b0;
    i = 0;
    @(negedge clk_i);
    while (!(wb.wr_byte || wb.wr_word || flow.load) && i < 6) begin
      @(negedge clk_i);
      i++;
    end
    if (r.op < CALBE_OP_REL_JUMP) begin
      m_sreg = s;
      if (r.op != CALBE_OP_ZERO_TEST || wb.wr_byte) chk("write", {1'b1, wd,
        (r.op > CALBE_OP_FILL_ONES) ? 5'h00 : r.rd_idx,
        wd ? e : {8'h00, e[7:0]}}, {wb.wr_byte | wb.wr_word, wb.wr_word, wb.addr,
        wd ? wb.data : {8'h00, wb.data[7:0]}});
    end else begin
      case (r.op)
        CALBE_OP_REL_JUMP, CALBE_OP_REL_CALL: e = r.pc + {{4{r.offs[11]}}, r.offs} + 16'h0001;
        CALBE_OP_POP_PC, CALBE_OP_INT_EXIT: e = stk.pop_back();
        default: e = r.target;
      endcase
      chk("target", {1'b1, e}, {flow.load, flow.target});
      lt = e;
      if (r.op inside {CALBE_OP_REL_CALL, CALBE_OP_IND_CALL, CALBE_OP_DIR_CALL}) begin
        e = r.pc + ((r.op == CALBE_OP_DIR_CALL) ? 16'h0002 : 16'h0001);
        chk("return", {1'b1, e}, {flow.push, flow.ret_addr});
        stk.push_back(e);
      end
      m_sreg[CALBE_FLAG_I] |= (r.op == CALBE_OP_INT_EXIT);
    end
    chk("flags", m_sreg, sreg);
    while (!ready_o) @(negedge clk_i);
  endtask
  // 308 operations of at most a dozen cycles, with ample margin
  initial begin
    #(50 * 8000);
    num_errors++;
    stop_test();
  end
  initial begin
    calbe_req_t r;
    logic [31:0] q;
    logic er;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, q, er);
    chk("flags reset", 32'h0, q);
    apb(1'b1, 12'h000, 32'h5a, q, er);
    apb(1'b0, 12'h000, 32'h0, q, er);
    chk("flags readback", 32'h5a, q);
    m_sreg = 8'h5a;
    en_i <= 1'b0;
    apb(1'b1, 12'h000, 32'h0, q, er);
    en_i <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, q, er);
    chk("frozen", 32'h5a, q);
    apb(1'b0, 12'h00c, 32'h0, q, er);
    chk("unmapped", 32'h1, {31'h0, er});
    for (int i = 0; i < 300; i++) begin
      r = '0;
      r.op = calbe_op_t'(6'(1 + rnd() % 28));
      r.rd_idx = 5'(rnd());
      {r.rd_val, r.rd_hi_val, r.src_val} = 24'(rnd());
      r.imm = r.src_val;
      run(r);
    end
    for (int i = 29; i < 37; i++) begin
      r = '0;
      r.op = calbe_op_t'(6'(i));
      {r.pc, r.target} = rnd();
      r.offs = {i == 29, 11'(rnd())};
      run(r);
    end
    apb(1'b0, 12'h004, 32'h0, q, er);
    chk("last pc", {16'h0000, lt}, q);
    apb(1'b0, 12'h008, 32'h0, q, er);
    chk("retired", 32'h01340000, q);
    stop_test();
  end
endmodule
`default_nettype wire
